// [verilog/fmoam_pkg.sv]
// package for the fiber converter oam pin control block
// assumes apb at 32 bits, one aligned word per register
package fmoam_pkg;
    localparam logic [7:0]  ADDR_LOOP_CTRL = 8'h2c;   // word index 0x0b
    localparam logic [7:0]  ADDR_MGMT0     = 8'h00;
    localparam logic [7:0]  ADDR_PORT18    = 8'h48;
    localparam logic [7:0]  ADDR_PORT28    = 8'h70;
    localparam logic [7:0]  ADDR_STATUS    = 8'h80;
    localparam logic [7:0]  ADDR_REPORT    = 8'h84;
    localparam int          LOOP_LO        = 2;
    localparam int          LOOP_HI        = 3;
    localparam int          MGMT_SPEED     = 13;
    localparam int          MGMT_AN        = 12;
    localparam int          MGMT_DPX       = 8;
    localparam int          P28_AN         = 7;
    localparam int          P28_SPEED      = 6;
    localparam int          P28_DPX        = 5;
    localparam int          P18_FFC        = 4;
    localparam int          RPT_PWR        = 0;
    localparam int          RPT_DIAG       = 3;
    localparam logic [1:0]  LOOP_FROM_STRAP = 2'h0;
    localparam logic [1:0]  LOOP_PHY1       = 2'h1;
    localparam logic [1:0]  LOOP_MAC2       = 2'h2;
    localparam int          FIFO_W          = 10;
    localparam int          FIFO_D          = 8;
    localparam logic [15:0] REPORT_CODE     = 16'h0001; // arbitrary
endpackage : fmoam_pkg

// [verilog/fmoam_stream_if.sv]
// stream carrier between loopback filter and fifo
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface fmoam_stream_if #(parameter int W = 10);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : fmoam_stream_if

// [verilog/fmoam_fifo.sv]
// fifo in the loopback data path
// assumes synchronous active-low reset on core_clk
`timescale 1ns/100ps
module fmoam_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    fmoam_stream_if.sink in_s,
    output logic [W-1:0] out_data,
    output logic         out_valid,
    input  wire logic    out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fmoam_fifo_state_t;
    fmoam_fifo_state_t st, next_st;
    logic [W-1:0] mem [D];
    logic push, pop;
    assign in_s.ready = (st.cnt != (AW+1)'(D));
    assign out_valid  = (st.cnt != '0);
    assign out_data   = mem[st.rp];
    assign push = in_s.valid && in_s.ready;
    assign pop  = out_valid && out_ready;
    always_comb begin
        next_st = st;
        if (push) next_st.wp = (st.wp == AW'(D-1)) ? '0 : st.wp + 1'b1;
        if (pop)  next_st.rp = (st.rp == AW'(D-1)) ? '0 : st.rp + 1'b1;
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) st <= '0;
        else st <= next_st;
        if (push) mem[st.wp] <= in_s.data;
    end
endmodule : fmoam_fifo

// [verilog/fmoam_top.sv]
// pin control, strap capture, report triggers and loopback filter
// assumes all inputs synchronous to core_clk, apb slave with zero wait
`timescale 1ns/100ps
module fmoam_top (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_down_detect_n,
    input  wire logic        diagnostic_fail_in,
    input  wire logic        far_end_fault,
    input  wire logic        partner_port_down,
    input  wire logic        loopback_active,
    input  wire logic        loopback_error_filter_sel,
    input  wire logic        loopback_point_sel,
    input  wire logic        missing_link_enable,
    input  wire logic        port1_autoneg_strap,
    input  wire logic        port1_speed_strap,
    input  wire logic        port1_duplex_strap,
    input  wire logic        port1_forced_flow_strap,
    output logic             port1_fault_status_n,
    output logic             report_valid,
    input  wire logic        report_ready,
    output logic [15:0]      report_status,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_is_oam,
    input  wire logic        rx_bad,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    input  wire logic        port1_rx_neg,
    output logic             port1_tx_neg,
    output logic             loop_at_phy1,
    output logic             missing_link_on,
    output logic             port1_autoneg_off,
    output logic             port1_speed_100,
    output logic             port1_full_duplex,
    output logic             port1_forced_flow
);
    typedef struct packed {
        logic        started;
        logic        s_filt;
        logic        s_point;
        logic        s_ml;
        logic        s_an;
        logic        s_spd;
        logic        s_dpx;
        logic        s_ffc;
        logic        pdd_q;
        logic        diag_q;
        logic        pend_pwr;
        logic        pend_diag;
        logic        rpt_valid;
        logic [15:0] rpt;
        logic [1:0]  loop_ctrl;
        logic [31:0] mgmt0;
        logic [31:0] port18;
        logic [31:0] port28;
        logic        fault_n;
        logic        in_frame;
        logic        drop;
        logic [31:0] rdata;
        logic        tx_bit;
    } fmoam_state_t;
    fmoam_state_t st, next_st;
    fmoam_stream_if #(.W(fmoam_pkg::FIFO_W)) lb_s ();
    logic [fmoam_pkg::FIFO_W-1:0] fifo_out;
    logic wr, rd, pdd_fall, diag_chg, keep;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pdd_fall = st.started && st.pdd_q && !power_down_detect_n;
    assign diag_chg = st.started && (st.diag_q != diagnostic_fail_in);
    assign keep = !rx_is_oam && !(st.s_filt && rx_bad);
    assign lb_s.valid = rx_valid && keep;
    assign lb_s.data  = {1'b0, rx_last, rx_data};
    assign rx_ready   = lb_s.ready;
    always_comb begin
        next_st = st;
        next_st.started = 1'b1;
        if (!st.started) begin
            next_st.s_filt  = loopback_error_filter_sel;
            next_st.s_point = loopback_point_sel;
            next_st.s_ml    = missing_link_enable;
            next_st.s_an    = port1_autoneg_strap;
            next_st.s_spd   = port1_speed_strap;
            next_st.s_dpx   = port1_duplex_strap;
            next_st.s_ffc   = port1_forced_flow_strap;
        end
        next_st.pdd_q  = power_down_detect_n;
        next_st.diag_q = diagnostic_fail_in;
        if (st.rpt_valid && report_ready) next_st.rpt_valid = 1'b0;
        if (!next_st.rpt_valid && (st.pend_pwr || st.pend_diag)) begin
            next_st.rpt_valid = 1'b1;
            next_st.rpt = '0;
            next_st.rpt[fmoam_pkg::RPT_PWR]  = !st.pdd_q;
            next_st.rpt[fmoam_pkg::RPT_DIAG] = st.diag_q;
            next_st.pend_pwr  = 1'b0;
            next_st.pend_diag = 1'b0;
        end
        if (pdd_fall) next_st.pend_pwr = 1'b1;
        if (diag_chg) next_st.pend_diag = 1'b1;
        next_st.fault_n = !(far_end_fault || partner_port_down || loopback_active);
        if (wr) begin
            unique case (paddr)
                fmoam_pkg::ADDR_LOOP_CTRL:
                    next_st.loop_ctrl = pwdata[fmoam_pkg::LOOP_HI:fmoam_pkg::LOOP_LO];
                fmoam_pkg::ADDR_MGMT0:  next_st.mgmt0  = pwdata;
                fmoam_pkg::ADDR_PORT18: next_st.port18 = pwdata;
                fmoam_pkg::ADDR_PORT28: next_st.port28 = pwdata;
                default: ;
            endcase
        end
        if (rd) begin
            unique case (paddr)
                fmoam_pkg::ADDR_LOOP_CTRL:
                    next_st.rdata = {28'h0, st.loop_ctrl, 2'h0};
                fmoam_pkg::ADDR_MGMT0:  next_st.rdata = st.mgmt0;
                fmoam_pkg::ADDR_PORT18: next_st.rdata = st.port18;
                fmoam_pkg::ADDR_PORT28: next_st.rdata = st.port28;
                fmoam_pkg::ADDR_STATUS:
                    next_st.rdata = {24'h0, st.s_ffc, st.s_dpx, st.s_spd, st.s_an,
                                     st.s_ml, st.s_point, st.s_filt,
                                     !st.fault_n};
                fmoam_pkg::ADDR_REPORT:
                    next_st.rdata = {fmoam_pkg::REPORT_CODE, st.rpt};
                default: next_st.rdata = '0;
            endcase
        end
        next_st.tx_bit = port1_rx_neg;
        if (lb_s.valid && lb_s.ready) next_st.in_frame = !rx_last;
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= '0;
            st.pdd_q   <= 1'b1;
            st.fault_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    fmoam_fifo #(.W(fmoam_pkg::FIFO_W), .D(fmoam_pkg::FIFO_D)) u_fifo (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_s      (lb_s),
        .out_data  (fifo_out),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );
    assign tx_data  = fifo_out[7:0];
    assign tx_last  = fifo_out[8];
    assign prdata   = st.rdata;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign port1_fault_status_n = st.fault_n;
    assign report_valid  = st.rpt_valid;
    assign report_status = st.rpt;
    assign port1_tx_neg  = st.tx_bit;
    assign loop_at_phy1 = (st.loop_ctrl == fmoam_pkg::LOOP_PHY1) ? 1'b1 :
                          (st.loop_ctrl == fmoam_pkg::LOOP_MAC2) ? 1'b0 : st.s_point;
    assign missing_link_on   = st.s_ml;
    assign port1_autoneg_off = st.s_an || st.mgmt0[fmoam_pkg::MGMT_AN]
                             || st.port28[fmoam_pkg::P28_AN];
    assign port1_speed_100   = st.s_spd || st.mgmt0[fmoam_pkg::MGMT_SPEED]
                             || st.port28[fmoam_pkg::P28_SPEED];
    assign port1_full_duplex = st.s_dpx || st.mgmt0[fmoam_pkg::MGMT_DPX]
                             || st.port28[fmoam_pkg::P28_DPX];
    assign port1_forced_flow = (st.s_ffc || st.port18[fmoam_pkg::P18_FFC])
                             && port1_full_duplex;
endmodule : fmoam_top

// [testbench/fmoam_props.sv]
// assertions on the oam pin control top ports
// assumes bound into fmoam_top, one clock core_clk
`timescale 1ns/100ps
module fmoam_props (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        far_end_fault,
    input wire logic        partner_port_down,
    input wire logic        loopback_active,
    input wire logic        port1_fault_status_n,
    input wire logic        power_down_detect_n,
    input wire logic        diagnostic_fail_in,
    input wire logic        report_valid,
    input wire logic        report_ready,
    input wire logic [15:0] report_status,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_is_oam,
    input wire logic        rx_bad,
    input wire logic        loopback_error_filter_sel,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        port1_rx_neg,
    input wire logic        port1_tx_neg
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire cause = far_end_fault | partner_port_down | loopback_active;
    wire take  = rx_valid & rx_ready & !tx_valid;
    sequence s_rpt(bit_ok);
        ##[1:8] report_valid && bit_ok;
    endsequence
    a_fault_on: assert property (cause |=> !port1_fault_status_n)
        else $error("fault output not low");
    a_fault_off: assert property (!cause |=> port1_fault_status_n)
        else $error("fault output low without cause");
    a_power_report: assert property ($fell(power_down_detect_n) |-> s_rpt(report_status[0]))
        else $error("no power fail report");
    a_diag_report: assert property ($changed(diagnostic_fail_in) |->
        s_rpt(report_status[3] == diagnostic_fail_in)) else $error("no diagnostic report");
    a_report_hold: assert property (report_valid && !report_ready |=>
        report_valid && $stable(report_status)) else $error("report dropped early");
    a_tx_follow: assert property ($past(resetn) |-> port1_tx_neg == $past(port1_rx_neg))
        else $error("tx line does not follow rx");
    a_drop_bytes: assert property (take && (rx_is_oam || rx_bad && loopback_error_filter_sel)
        |=> !tx_valid) else $error("dropped byte looped");
    a_pass_bytes: assert property (take && !rx_is_oam && !(rx_bad && loopback_error_filter_sel)
        |=> tx_valid && tx_data == $past(rx_data)) else $error("good byte not looped");
endmodule : fmoam_props
bind fmoam_top fmoam_props chk (.*);

// [testbench/fmoam_far_end.sv]
// far-end converter model: takes looped bytes and condition reports
// assumes stall driven by the bench
`timescale 1ns/100ps
module fmoam_far_end (
    input  wire logic        core_clk,
    input  wire logic        stall,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    input  wire logic        report_valid,
    input  wire logic [15:0] report_status,
    output logic             report_ready
);
    logic [7:0]  got [$];
    logic [15:0] last_rep = 16'h0000;
    int          n_rep = 0;
    initial tx_ready = 1'h0;
    initial report_ready = 1'h0;
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        if (report_valid && report_ready) begin
            last_rep = report_status;
            n_rep++;
        end
        tx_ready <= !stall;
        report_ready <= !stall;
    end
endmodule : fmoam_far_end

// [testbench/fmoam_top_test.sv]
// self-checking bench for the oam pin control block
// assumes fmoam_top, fmoam_far_end and bound fmoam_props
`timescale 1ns/100ps
module fmoam_top_test;
    logic        core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00, rx_data = 8'h00, tx_data, ca [7];
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        power_down_detect_n = 1'h1, diagnostic_fail_in = 1'h0, stall = 1'h0;
    logic        far_end_fault = 1'h0, partner_port_down = 1'h0, loopback_active = 1'h0;
    logic        loopback_error_filter_sel = 1'h0, loopback_point_sel = 1'h0;
    logic        missing_link_enable = 1'h0, port1_autoneg_strap = 1'h0, port1_speed_strap = 1'h0;
    logic        port1_duplex_strap = 1'h0, port1_forced_flow_strap = 1'h0, rx_last = 1'h0;
    logic        rx_valid = 1'h0, rx_is_oam = 1'h0, rx_bad = 1'h0, port1_rx_neg = 1'h0;
    logic [15:0] report_status;
    logic        pready, pslverr, port1_fault_status_n, report_valid, report_ready, rx_ready;
    logic        tx_valid, tx_last, tx_ready, port1_tx_neg, loop_at_phy1, missing_link_on;
    logic        port1_autoneg_off, port1_speed_100, port1_full_duplex, port1_forced_flow;
    logic [7:0]  exp_q [$];
    int          fails = 0, n_tests = 0, cb [7], ce [7];
    wire  [3:0]  cfg = {port1_autoneg_off, port1_speed_100, port1_full_duplex, port1_forced_flow};
    fmoam_top uut (.*);
    fmoam_far_end far (.*);
    always #2 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic rst();
        resetn <= 1'h0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'h1;
        repeat (2) @(posedge core_clk);
    endtask : rst
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) @(posedge core_clk);
        q = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask : apb
    task automatic send(input logic [7:0] d, input logic oam, input logic bad);
        rx_valid  <= 1'h1;
        rx_data   <= d;
        rx_is_oam <= oam;
        rx_bad    <= bad;
        @(posedge core_clk);
        while (rx_ready !== 1'h1) @(posedge core_clk);
        if (!oam && !(bad && loopback_error_filter_sel)) exp_q.push_back(d);
    endtask : send
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
    initial begin
        ca = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h70, 8'h70, 8'h48};
        cb = '{12, 13, 8, 7, 6, 5, 4};
        ce = '{3, 2, 1, 3, 2, 1, 0};
        rst();
        chk(32'(missing_link_on), 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, fmoam_pkg::ADDR_LOOP_CTRL, 32'(i << 2));
            chk(32'(loop_at_phy1), 32'(i == 1));
        end
        for (int i = 0; i < 7; i++) begin
            if (i == 6) apb(1'h1, fmoam_pkg::ADDR_MGMT0, 32'h1 << fmoam_pkg::MGMT_DPX);
            apb(1'h1, ca[i], 32'h1 << cb[i]);
            chk(32'(cfg), (32'h1 << ce[i]) | ((i == 6) ? 32'h2 : 32'h0));
            apb(1'h0, ca[i], 32'h0);
            chk(q, 32'h1 << cb[i]);
            apb(1'h1, ca[i], 32'h0);
        end
        apb(1'h0, 8'h40, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 3; i++) begin
            {far_end_fault, partner_port_down, loopback_active} <= 3'h1 << i;
            port1_rx_neg <= ~i[0];
            repeat (2) @(posedge core_clk);
            chk(32'(port1_fault_status_n), 32'h0);
            chk(32'(port1_tx_neg), {31'h0, ~i[0]});
            {far_end_fault, partner_port_down, loopback_active} <= 3'h0;
            repeat (2) @(posedge core_clk);
            chk(32'(port1_fault_status_n), 32'h1);
        end
        power_down_detect_n <= 1'h0;
        repeat (8) @(posedge core_clk);
        chk(32'(far.last_rep[0]), 32'h1);
        diagnostic_fail_in <= 1'h1;
        repeat (8) @(posedge core_clk);
        chk(32'(far.last_rep[3]), 32'h1);
        diagnostic_fail_in <= 1'h0;
        power_down_detect_n <= 1'h1;
        repeat (8) @(posedge core_clk);
        chk({28'h0, far.last_rep[3:0]}, 32'h0);
        chk(32'(far.n_rep), 32'h3);
        send(8'ha1, 1'h0, 1'h0);
        send(8'ha2, 1'h1, 1'h0);
        send(8'ha3, 1'h0, 1'h1);
        rx_valid <= 1'h0;
        repeat (4) @(posedge core_clk);
        stall <= 1'h1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) send(8'(16 + i), 1'h0, 1'h0);
        rx_valid <= 1'h0;
        @(posedge core_clk);
        chk(32'(rx_ready), 32'h0);
        stall <= 1'h0;
        repeat (12) @(posedge core_clk);
        chk(32'(tx_valid), 32'h0);
        {loopback_error_filter_sel, loopback_point_sel, missing_link_enable, port1_autoneg_strap,
            port1_speed_strap, port1_duplex_strap, port1_forced_flow_strap} <= 7'h7f;
        rst();
        missing_link_enable <= 1'h0;
        repeat (2) @(posedge core_clk);
        chk({26'h0, loop_at_phy1, missing_link_on, cfg}, 32'h3f);
        apb(1'h1, fmoam_pkg::ADDR_LOOP_CTRL, 32'h8);
        chk(32'(loop_at_phy1), 32'h0);
        send(8'hb1, 1'h0, 1'h0);
        send(8'hb2, 1'h1, 1'h0);
        send(8'hb3, 1'h0, 1'h1);
        rx_valid <= 1'h0;
        repeat (6) @(posedge core_clk);
        chk(32'(far.got.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) chk(32'(far.got[i]), 32'(exp_q[i]));
        print_verdict();
    end
endmodule : fmoam_top_test
